// file: common/scms_pkg.sv
/*
 * constants of the serial channel mode and status block: register offsets,
 * field positions, reset values, codes and bit timing.
 * assumes a 32-bit apb slave on a 125 mhz pclk.
 */
package scms_pkg;
	// byte offsets
	localparam logic [11:0] OFS_MOD0 = 12'h000;
	localparam logic [11:0] OFS_MOD1 = 12'h004;
	localparam logic [11:0] OFS_MOD2 = 12'h008;
	localparam logic [11:0] OFS_CR = 12'h00c;
	localparam logic [11:0] OFS_DATA = 12'h010;
	// mode_control_zero
	localparam int MOD0_RXE = 6;
	localparam int MOD0_SM = 2;
	// mode_control_one
	localparam int MOD1_TXE = 4;
	// mode_control_two
	localparam int MOD2_TBEMP = 7;
	localparam int MOD2_RBFLL = 6;
	localparam int MOD2_TXRUN = 5;
	localparam int MOD2_SBLEN = 4;
	localparam int MOD2_ORDER = 3;
	localparam int MOD2_WBUF = 2;
	localparam int MOD2_SOFT_RESET_CODE = 0;
	localparam logic MOD2_TBEMP_RST = 1'b1;
	// channel_control_reg
	localparam int CR_SCLK_OUT = 0;
	localparam int CR_FERR = 2;
	localparam int CR_PERR = 3;
	localparam int CR_OERR = 4;
	// transfer modes
	localparam logic [1:0] SM_IO = 2'h0;
	localparam logic [1:0] SM_U7 = 2'h1;
	localparam logic [1:0] SM_U8 = 2'h2;
	// soft reset codes and delay from recognition to execution
	localparam logic [1:0] SOFT_RESET_CODE_ARM = 2'h1;
	localparam logic [1:0] SOFT_RESET_CODE_FIRE = 2'h2;
	localparam int SOFT_RESET_CODE_DELAY = 2;
	// bit timing in pclk cycles
	localparam logic [15:0] UART_BIT_CYCLES = 16'h0010;
	localparam logic [15:0] UART_HALF_CYCLES = 16'h0008;
	localparam logic [7:0] SCLK_HALF_CYCLES = 8'h04;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scms_rx_t;
endpackage : scms_pkg

// file: hw/scms_tx_shift.sv
/*
 * transmit shift register: frames a character for uart or i/o mode and
 * moves one bit per step pulse.
 * assumes step pulses come from the caller's bit timing, on pclk.
 */
module scms_tx_shift (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic init,
	input wire logic start,
	input wire logic step,
	input wire logic [8:0] data,
	input wire logic [3:0] nbits,
	input wire logic uart,
	input wire logic two_stop,
	input wire logic msb_first,
	output logic busy,
	output logic last,
	output logic txd
);
	typedef struct packed {
		logic busy;
		logic line;
		logic [11:0] shreg;
		logic [3:0] left;
	} scms_txs_t;

	scms_txs_t s_q, s_d;
	logic [11:0] frame;
	logic [3:0] len;

	always_comb begin
		frame = 12'hfff;
		len = 4'h8;
		if (uart) begin
			frame[0] = 1'b0;
			for (int i = 0; i < 9; i++) begin
				if (i < int'(nbits)) frame[i + 1] = data[i];
			end
			len = 4'(nbits + (two_stop ? 4'h3 : 4'h2));
		end else begin
			for (int i = 0; i < 8; i++) begin
				frame[i] = msb_first ? data[7 - i] : data[i];
			end
		end
	end

	always_comb begin
		s_d = s_q;
		if (init) begin
			s_d.busy = 1'b0;
			s_d.line = 1'b1;
			s_d.left = 4'h0;
		end else if (start && !s_q.busy) begin
			s_d.busy = 1'b1;
			s_d.shreg = frame;
			s_d.line = frame[0];
			s_d.left = len;
		end else if (step && s_q.busy) begin
			s_d.shreg = {1'b1, s_q.shreg[11:1]};
			s_d.left = s_q.left - 4'h1;
			s_d.line = s_q.shreg[1];
			if (s_q.left == 4'h1) begin
				s_d.busy = 1'b0;
				s_d.line = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{busy: 1'b0, line: 1'b1, shreg: 12'hfff, left: 4'h0};
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign last = s_q.busy && (s_q.left == 4'h1);
	assign txd = s_q.line;
endmodule : scms_tx_shift

// file: hw/scms_channel.sv
/*
 * mode control and status of one serial channel with its apb registers,
 * transmit/receive double buffers, uart and clocked i/o shifting and the
 * two-step software reset.
 * assumes an apb master on pclk; rxd and sclk_in come from outside the
 * clock domain and are synchronised here.
 */
// Added by the designer: register access over APB and the register offsets.
// How it works
// - buffer empty flag sets on move, resets one
// - writing transmit data clears buffer empty flag
// - receive full sets on move, read clears
// - flags meaningless without double buffering
// - in-transmission flag high while shifting
// - uart sends one or two stop bits
// - receiver checks only one stop bit
// - i/o mode bit order selectable
// - buffer enable covers three transfer cases; the code uses it only for i/o receive on its own clock
// - receive always double buffered in two cases
// - code sequence ending ten triggers soft reset
// - soft reset clears enables, flags, errors
// - soft reset executes two cycles later
// - transmit enable gates every transfer mode
module scms_channel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic txd,
	input wire logic rxd,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe
);
	localparam int SOFT_RESET_CODE_DELAY_W = scms_pkg::SOFT_RESET_CODE_DELAY;

	typedef struct packed {
		logic rxe;
		logic [1:0] sm;
		logic txe;
		logic tbemp;
		logic rbfll;
		logic sblen;
		logic order;
		logic wbuf;
		logic [1:0] soft_reset_code;
		logic armed;
		logic [SOFT_RESET_CODE_DELAY_W-1:0] rst_pipe;
		logic sclk_own;
		logic ferr;
		logic perr;
		logic oerr;
		logic [8:0] tx_buf;
		logic tx_full;
		logic [8:0] rx_buf;
		logic [31:0] prdata;
		logic rxd_m;
		logic rxd_s;
		logic rxd_p;
		logic sclk_m;
		logic sclk_s;
		logic sclk_p;
		logic sclk_q;
		logic [7:0] sclk_cnt;
		logic [15:0] baud_cnt;
		logic io_skip;
		scms_pkg::scms_rx_t rx_st;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [8:0] rx_sh;
	} scms_state_t;

	scms_state_t s_q, s_d;

	// register index of an address, 3'h7 when unmapped
	function automatic logic [2:0] reg_index(input logic [11:0] addr);
		case (addr)
			scms_pkg::OFS_MOD0: reg_index = 3'h0;
			scms_pkg::OFS_MOD1: reg_index = 3'h1;
			scms_pkg::OFS_MOD2: reg_index = 3'h2;
			scms_pkg::OFS_CR: reg_index = 3'h3;
			scms_pkg::OFS_DATA: reg_index = 3'h4;
			default: reg_index = 3'h7;
		endcase
	endfunction : reg_index

	// character length per transfer mode
	function automatic logic [3:0] char_bits(input logic [1:0] sm);
		case (sm)
			scms_pkg::SM_IO: char_bits = 4'h8;
			scms_pkg::SM_U7: char_bits = 4'h7;
			scms_pkg::SM_U8: char_bits = 4'h8;
			default: char_bits = 4'h9;
		endcase
	endfunction : char_bits

	logic uart;
	logic [3:0] nbits;
	logic tx_busy;
	logic tx_last;
	logic tx_start;
	logic tx_step;
	logic soft_exec;
	logic setup;
	logic access;
	logic [2:0] idx;
	logic [2:0] acc_idx;
	logic [31:0] rdata;
	logic sclk_src;
	logic sclk_rise;
	logic sclk_fall;
	logic sclk_run;
	logic rx_done;
	logic [8:0] rx_word;
	logic [1:0] code;

	assign uart = (s_q.sm != scms_pkg::SM_IO);
	assign nbits = char_bits(s_q.sm);
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign idx = reg_index(paddr);
	assign acc_idx = access ? idx : 3'h7;
	assign code = pwdata[scms_pkg::MOD2_SOFT_RESET_CODE +: 2];
	assign soft_exec = s_q.rst_pipe[SOFT_RESET_CODE_DELAY_W-1];
	assign sclk_src = s_q.sclk_own ? s_q.sclk_q : s_q.sclk_s;
	assign sclk_rise = !s_q.sclk_p && sclk_src;
	assign sclk_fall = s_q.sclk_p && !sclk_src;
	// the generator stops only with the line high so no stray edge is seen
	assign sclk_run = !uart && s_q.sclk_own &&
		(tx_busy || (s_q.rxe && (s_q.wbuf || !s_q.rbfll)) || !s_q.sclk_q);
	assign tx_start = s_q.txe && s_q.tx_full && !tx_busy && !soft_exec;
	// i/o mode: the first falling edge only opens the frame; the last bit
	// ends on the eighth rising edge so the clock idles high afterwards
	assign tx_step = uart ? (s_q.baud_cnt == scms_pkg::UART_BIT_CYCLES - 16'h1)
		: ((sclk_fall && !s_q.io_skip) || (sclk_rise && tx_last));

	scms_tx_shift u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.init(soft_exec),
		.start(tx_start),
		.step(tx_step),
		.data(s_q.tx_buf),
		.nbits(nbits),
		.uart(uart),
		.two_stop(s_q.sblen),
		.msb_first(s_q.order),
		.busy(tx_busy),
		.last(tx_last),
		.txd(txd)
	);

	// read mux, sampled in the setup cycle so prdata comes from a flop
	always_comb begin
		rdata = 32'h0000_0000;
		case (idx)
			3'h0: begin
				rdata[scms_pkg::MOD0_RXE] = s_q.rxe;
				rdata[scms_pkg::MOD0_SM +: 2] = s_q.sm;
			end
			3'h1: rdata[scms_pkg::MOD1_TXE] = s_q.txe;
			3'h2: begin
				rdata[scms_pkg::MOD2_TBEMP] = s_q.tbemp;
				rdata[scms_pkg::MOD2_RBFLL] = s_q.rbfll;
				rdata[scms_pkg::MOD2_TXRUN] = tx_busy;
				rdata[scms_pkg::MOD2_SBLEN] = s_q.sblen;
				rdata[scms_pkg::MOD2_ORDER] = s_q.order;
				rdata[scms_pkg::MOD2_WBUF] = s_q.wbuf;
				rdata[scms_pkg::MOD2_SOFT_RESET_CODE +: 2] = s_q.soft_reset_code;
			end
			3'h3: begin
				rdata[scms_pkg::CR_SCLK_OUT] = s_q.sclk_own;
				rdata[scms_pkg::CR_FERR] = s_q.ferr;
				rdata[scms_pkg::CR_PERR] = s_q.perr;
				rdata[scms_pkg::CR_OERR] = s_q.oerr;
			end
			3'h4: rdata[8:0] = s_q.rx_buf;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		s_d = s_q;
		rx_done = 1'b0;
		rx_word = s_q.rx_sh;

		// pin synchronisers; logic reads the second stage, and the third stage too for the rxd start edge
		s_d.rxd_m = rxd;
		s_d.rxd_s = s_q.rxd_m;
		s_d.rxd_p = s_q.rxd_s;
		s_d.sclk_m = sclk_in;
		s_d.sclk_s = s_q.sclk_m;
		s_d.sclk_p = sclk_src;

		// internal shift clock
		if (sclk_run) begin
			if (s_q.sclk_cnt == scms_pkg::SCLK_HALF_CYCLES - 8'h01) begin
				s_d.sclk_cnt = 8'h00;
				s_d.sclk_q = !s_q.sclk_q;
			end else begin
				s_d.sclk_cnt = s_q.sclk_cnt + 8'h01;
			end
		end else begin
			s_d.sclk_cnt = 8'h00;
			s_d.sclk_q = 1'b1;
		end

		// uart bit timer and i/o frame opening
		if (tx_start || !tx_busy || tx_step) begin
			s_d.baud_cnt = 16'h0000;
		end else begin
			s_d.baud_cnt = s_q.baud_cnt + 16'h0001;
		end
		if (tx_start) begin
			s_d.io_skip = 1'b1;
		end else if (sclk_fall) begin
			s_d.io_skip = 1'b0;
		end

		// transmit double buffer hand-over
		if (tx_start) begin
			s_d.tx_full = 1'b0;
			s_d.tbemp = 1'b1;
		end

		// receiver
		case (s_q.rx_st)
			scms_pkg::RX_IDLE: begin
				s_d.rx_cnt = 16'h0000;
				s_d.rx_bits = 4'h0;
				if (s_q.rxe && uart && s_q.rxd_p && !s_q.rxd_s) begin
					s_d.rx_st = scms_pkg::RX_START;
				end else if (s_q.rxe && !uart) begin
					s_d.rx_st = scms_pkg::RX_DATA;
				end
			end
			scms_pkg::RX_START: begin
				if (s_q.rx_cnt == scms_pkg::UART_HALF_CYCLES - 16'h1) begin
					s_d.rx_cnt = 16'h0000;
					s_d.rx_st = s_q.rxd_s ? scms_pkg::RX_IDLE : scms_pkg::RX_DATA;
				end else begin
					s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
				end
			end
			scms_pkg::RX_DATA: begin
				if (uart) begin
					if (s_q.rx_cnt == scms_pkg::UART_BIT_CYCLES - 16'h1) begin
						s_d.rx_cnt = 16'h0000;
						s_d.rx_sh = {s_q.rxd_s, s_q.rx_sh[8:1]};
						s_d.rx_bits = s_q.rx_bits + 4'h1;
						if (s_q.rx_bits == nbits - 4'h1) s_d.rx_st = scms_pkg::RX_STOP;
					end else begin
						s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
					end
				end else if (!s_q.rxe) begin
					s_d.rx_st = scms_pkg::RX_IDLE;
				end else if (sclk_rise) begin
					s_d.rx_sh = s_q.order ? {1'b0, s_q.rx_sh[6:0], s_q.rxd_s}
						: {1'b0, s_q.rxd_s, s_q.rx_sh[7:1]};
					s_d.rx_bits = s_q.rx_bits + 4'h1;
					if (s_q.rx_bits == 4'h7) begin
						s_d.rx_bits = 4'h0;
						rx_done = 1'b1;
						rx_word = s_d.rx_sh;
					end
				end
			end
			scms_pkg::RX_STOP: begin
				if (s_q.rx_cnt == scms_pkg::UART_BIT_CYCLES - 16'h1) begin
					// one stop bit is checked whatever the stop length
					if (!s_q.rxd_s) s_d.ferr = 1'b1;
					rx_done = 1'b1;
					rx_word = s_q.rx_sh >> (4'h9 - nbits);
					s_d.rx_st = scms_pkg::RX_IDLE;
				end else begin
					s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
				end
			end
			default: s_d.rx_st = scms_pkg::RX_IDLE;
		endcase

		// receive double buffer: uart and external clock always buffer
		if (acc_idx == 3'h2 && !pwrite && s_q.prdata[scms_pkg::MOD2_RBFLL]) begin
			s_d.rbfll = 1'b0;
		end
		if (rx_done) begin
			if (s_q.rbfll && (uart || !s_q.sclk_own || s_q.wbuf)) begin
				s_d.oerr = 1'b1;
			end
			s_d.rx_buf = rx_word;
			s_d.rbfll = 1'b1;
		end

		// apb
		if (setup) begin
			s_d.prdata = rdata;
		end
		if (pwrite) begin
			case (acc_idx)
				3'h0: begin
					s_d.rxe = pwdata[scms_pkg::MOD0_RXE];
					s_d.sm = pwdata[scms_pkg::MOD0_SM +: 2];
				end
				3'h1: s_d.txe = pwdata[scms_pkg::MOD1_TXE];
				3'h2: begin
					s_d.sblen = pwdata[scms_pkg::MOD2_SBLEN];
					s_d.order = pwdata[scms_pkg::MOD2_ORDER];
					s_d.wbuf = pwdata[scms_pkg::MOD2_WBUF];
					s_d.soft_reset_code = code;
					// a fire code counts only straight after an arm code
					s_d.armed = (code == scms_pkg::SOFT_RESET_CODE_ARM);
					s_d.rst_pipe[0] = s_q.armed && (code == scms_pkg::SOFT_RESET_CODE_FIRE);
				end
				3'h3: s_d.sclk_own = pwdata[scms_pkg::CR_SCLK_OUT];
				3'h4: begin
					s_d.tx_buf = pwdata[8:0];
					s_d.tx_full = 1'b1;
					s_d.tbemp = 1'b0;
				end
				default: s_d.prdata = s_q.prdata;
			endcase
		end
		if (!(pwrite && acc_idx == 3'h2)) begin
			s_d.rst_pipe[0] = 1'b0;
		end
		for (int i = 1; i < SOFT_RESET_CODE_DELAY_W; i++) begin
			s_d.rst_pipe[i] = s_q.rst_pipe[i - 1];
		end

		// software reset wins over everything it touches
		if (soft_exec) begin
			s_d.rxe = 1'b0;
			s_d.txe = 1'b0;
			s_d.tbemp = 1'b0;
			s_d.rbfll = 1'b0;
			s_d.ferr = 1'b0;
			s_d.perr = 1'b0;
			s_d.oerr = 1'b0;
			s_d.tx_full = 1'b0;
			s_d.rx_st = scms_pkg::RX_IDLE;
			s_d.rx_bits = 4'h0;
			s_d.rx_cnt = 16'h0000;
			s_d.io_skip = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.tbemp <= scms_pkg::MOD2_TBEMP_RST;
			s_q.rxd_m <= 1'b1;
			s_q.rxd_s <= 1'b1;
			s_q.rxd_p <= 1'b1;
			s_q.sclk_m <= 1'b1;
			s_q.sclk_s <= 1'b1;
			s_q.sclk_p <= 1'b1;
			s_q.sclk_q <= 1'b1;
			s_q.rx_st <= scms_pkg::RX_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	// zero-wait slave: every access ends in its first access cycle
	assign pready = 1'b1;
	assign pslverr = access && (idx == 3'h7);
	assign sclk_out = s_q.sclk_q;
	assign sclk_oe = !uart && s_q.sclk_own;
endmodule : scms_channel

// file: verification/scms_channel_properties.sv
/* assertions on the serial channel ports.
   assumes one pclk domain, presetn async low. */
module scms_channel_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic rxd,
	input wire logic sclk_in,
	input wire logic sclk_out,
	input wire logic sclk_oe
);
	typedef struct packed {
		logic armed;
		logic fresh;
		logic held;
		logic txe;
		logic [2:0] fld;
		logic [7:0] off;
	} scms_chk_t;
	scms_chk_t st_q, st_d;
	logic wr, wr2, fire, rd0, rd2, mapped;
	assign wr = psel && penable && pwrite;
	assign wr2 = wr && paddr == scms_pkg::OFS_MOD2;
	assign fire = wr2 && pwdata[1:0] == scms_pkg::SOFT_RESET_CODE_FIRE && st_q.armed;
	assign rd0 = psel && !penable && !pwrite && paddr == scms_pkg::OFS_MOD0;
	assign rd2 = psel && !penable && !pwrite && paddr == scms_pkg::OFS_MOD2;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
	always_comb begin
		st_d = st_q;
		if (wr2) begin
			st_d.armed = pwdata[1:0] == scms_pkg::SOFT_RESET_CODE_ARM;
			st_d.fld = pwdata[4:2];
		end
		if (wr && paddr == scms_pkg::OFS_MOD1) begin
			st_d.txe = pwdata[scms_pkg::MOD1_TXE];
			st_d.held = st_q.held && !pwdata[scms_pkg::MOD1_TXE];
		end
		if (wr && paddr == scms_pkg::OFS_DATA) begin
			st_d.fresh = 1'b0;
			st_d.held = !st_q.txe;
		end
		if (fire) begin
			st_d.txe = 1'b0;
			st_d.fresh = 1'b0;
			st_d.held = 1'b0;
		end
		// saturates above the longest frame so a late stop bit cannot fire it
		st_d.off = st_q.txe ? 8'h00 : st_q.off + {7'h0, st_q.off != 8'hff};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= scms_chk_t'{fresh: 1'b1, default: '0};
		end else begin
			st_q <= st_d;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_tbemp_reset: assert property (rd2 && st_q.fresh |=> prdata[7])
		else $error("empty flag low before any data");
	a_tbemp_held: assert property (rd2 && st_q.held |=> !prdata[7] && !prdata[5])
		else $error("held data not shown as waiting");
	a_rbfll_clear: assert property (psel && penable && !pwrite && paddr == 12'h008
		&& prdata[6] ##1 rd2 |=> !prdata[6])
		else $error("full flag survived a read");
	a_mod2_upper: assert property (rd2 |=> prdata[31:8] == 24'h0)
		else $error("upper bits not zero");
	a_mod2_fields: assert property (rd2 |=> prdata[4:2] == st_q.fld)
		else $error("mode fields lost");
	a_soft_reset_code_delay: assert property (fire ##3 rd0 |=> !prdata[scms_pkg::MOD0_RXE])
		else $error("receive enable kept after soft reset");
	a_txe_gate: assert property (st_q.off == 8'hff |-> txd)
		else $error("line active with transmit off");
	a_err_map: assert property (pslverr == (psel && penable && !mapped))
		else $error("slave error misplaced");
	a_ready_now: assert property (psel && penable |-> pready)
		else $error("access phase not answered at once");
	a_sclk_idle: assert property (!sclk_oe ##1 !sclk_oe |-> sclk_out)
		else $error("shift clock output not parked high");
	c_soft_reset_code: cover property (fire);
	c_rbfll: cover property (rd2 ##1 prdata[6]);
	c_oe: cover property (sclk_oe);
endmodule : scms_channel_properties

bind scms_channel scms_channel_properties i_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
	.sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe));

// file: verification/scms_peer.sv
/* serial peer: uart frame monitor and sender, external shift clock master.
   assumes 16 pclk of 8 ns per uart bit. */
module scms_peer (
	input wire logic txd,
	output logic rxd,
	output logic sclk_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mon_on;
	logic [7:0] sh;
	logic [7:0] rx_q[$];
	realtime t_q[$];
	initial begin
		rxd = 1'b1;
		sclk_in = 1'b1; // shift clock stands still between frames
		mon_on = 1'b0;
	end
	// start-to-start spacing shows the stop length
	always begin
		@(negedge txd);
		if (mon_on) begin
			t_q.push_back($realtime);
			#192;
			for (int i = 0; i < 8; i++) begin
				sh = {txd, sh[7:1]};
				#128;
			end
			rx_q.push_back(sh);
		end
	end
	task automatic uart_send(input logic [7:0] d);
		// start off the pclk edge so the synchroniser never races the pin
		#3;
		rxd = 1'b0;
		#128;
		for (int i = 0; i < 8; i++) begin
			rxd = d[i];
			#128;
		end
		rxd = 1'b1; // one stop bit only, next start follows at once
		#128;
	endtask : uart_send
	task automatic io_xfer(input logic [7:0] d, output logic [7:0] q);
		#3;
		for (int i = 0; i < 8; i++) begin
			sclk_in = 1'b0;
			rxd = d[7 - i];
			#32;
			sclk_in = 1'b1;
			#16;
			q = {q[6:0], txd};
			#16;
		end
		rxd = ~d[0]; // released line shows no stale bit
	endtask : io_xfer
endmodule : scms_peer

// file: verification/tb_top.sv
/* self-checking bench for the serial channel mode and status block.
   assumes the peer model on the serial pins. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] M0 = scms_pkg::OFS_MOD0;
	localparam logic [11:0] M1 = scms_pkg::OFS_MOD1;
	localparam logic [11:0] M2 = scms_pkg::OFS_MOD2;
	localparam logic [11:0] CR = scms_pkg::OFS_CR;
	localparam logic [11:0] DT = scms_pkg::OFS_DATA;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic txd, rxd, sclk_in, sclk_out, sclk_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, f;
	logic [7:0] a, b, q;
	int n_errors, check_count;
	int cyc = 0;
	scms_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .txd(txd), .rxd(rxd), .sclk_in(sclk_in), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe));
	scms_peer i_peer (.txd(txd), .rxd(rxd), .sclk_in(sclk_in));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
	endfunction : rev8
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	// keep holds psel so the next transfer starts without an idle cycle
	task automatic bus(input logic [11:0] ad, input logic w, input logic [31:0] wd,
		input logic keep = 1'b0);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		if (!keep) begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : bus
	task automatic rdc(input logic [11:0] ad, input logic [31:0] exp, input logic k = 1'b0);
		bus(ad, 1'b0, 32'h0, k);
		chk(rd, exp);
	endtask : rdc
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		n_errors = 0;
		check_count = 0;
		void'($urandom(32'hd4ad));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(M2, 32'h80);
		bus(12'h014, 1'b1, $urandom);
		bus(12'h014, 1'b0, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		bus(M0, 1'b1, 32'h08);
		i_peer.mon_on = 1'b1;
		for (int s = 0; s < 2; s++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			f = 32'(s << 4) | 32'h4;
			bus(M2, 1'b1, ($urandom & 32'hffffff00) | f);
			rdc(M2, 32'h80 | f);
			bus(DT, 1'b1, {24'h0, a});
			rdc(M2, f);
			bus(M1, 1'b1, 32'h10);
			rdc(M2, 32'ha0 | f);
			bus(DT, 1'b1, {24'h0, b});
			rdc(M2, 32'h20 | f);
			repeat (2 * (10 + s) * 16 + 16) @(posedge pclk);
			rdc(M2, 32'h80 | f);
			bus(M1, 1'b1, 32'h0);
			chk({24'h0, i_peer.rx_q[0]}, {24'h0, a});
			chk({24'h0, i_peer.rx_q[1]}, {24'h0, b});
			chk(32'(int'(i_peer.t_q[1] - i_peer.t_q[0]) / 128), 32'(10 + s));
			i_peer.rx_q.delete();
			i_peer.t_q.delete();
		end
		i_peer.mon_on = 1'b0;
		bus(M2, 1'b1, 32'h0);
		bus(M0, 1'b1, 32'h48);
		i_peer.uart_send(a);
		repeat (8) @(posedge pclk);
		rdc(M2, 32'hc0, 1'b1);
		rdc(M2, 32'h80);
		rdc(DT, {24'h0, a});
		i_peer.uart_send(b);
		i_peer.uart_send(~b);
		repeat (8) @(posedge pclk);
		rdc(DT, {24'h0, ~b});
		rdc(CR, 32'h10);
		bus(M1, 1'b1, 32'h10);
		bus(M2, 1'b1, 32'h1);
		bus(M2, 1'b1, 32'h3);
		bus(M2, 1'b1, 32'h2);
		rdc(M0, 32'h48);
		bus(M2, 1'b1, 32'h1, 1'b1);
		bus(M2, 1'b1, 32'h2, 1'b1);
		rdc(M0, 32'h48, 1'b1);
		rdc(M0, 32'h08);
		rdc(M1, 32'h0);
		rdc(M2, 32'h2);
		rdc(CR, 32'h0);
		bus(M1, 1'b1, 32'h10);
		bus(DT, 1'b1, {24'h0, b});
		repeat (40) @(posedge pclk);
		repeat (2) begin
			bus(M2, 1'b1, 32'h1);
			bus(M2, 1'b1, 32'h2);
		end
		repeat (2) @(posedge pclk);
		rdc(M2, 32'h2);
		chk({31'h0, txd}, 32'h1);
		bus(M0, 1'b1, 32'h40);
		bus(CR, 1'b1, 32'h1);
		chk({31'h0, sclk_oe}, 32'h1);
		// own clock, no buffering: one byte of the idle line, then the clock parks high
		repeat (80) @(posedge pclk);
		chk({31'h0, sclk_out}, 32'h1);
		rdc(DT, 32'hff);
		bus(CR, 1'b1, 32'h0);
		for (int o = 0; o < 2; o++) begin
			bus(M2, 1'b1, 32'(o << 3));
			bus(M1, 1'b1, 32'h10);
			a = 8'($urandom);
			bus(DT, 1'b1, {24'h0, a});
			repeat (4) @(posedge pclk);
			b = 8'($urandom);
			i_peer.io_xfer(b, q);
			repeat (8) @(posedge pclk);
			chk({24'h0, q}, {24'h0, (o == 1) ? a : rev8(a)});
			rdc(M2, 32'hc0 | 32'(o << 3));
			rdc(DT, {24'h0, (o == 1) ? b : rev8(b)});
		end
		final_report();
	end
endmodule : tb_top
